// ### rtl/bbsd_params.svh
// Purpose: Constants for the branch and bit-set decode block.
// Assumes: Included by bare name from design files.
// Notes: Definitions only.
`ifndef BBSD_PARAMS_SVH
`define BBSD_PARAMS_SVH
// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define BBSD_OP_BRANCH_TOP 5'h1A
`define BBSD_OP_SETBIT_TOP 4'h8
`define BBSD_OP_BCOND_TOP 5'h1C
`define BBSD_OP_BCOND_Z 3'h1
`define BBSD_OP_BCOND_OV 3'h5
`define BBSD_OP_BCOND_C 3'h3
`define BBSD_OP_BCOND_N 3'h7
`define BBSD_IDX_LIMIT 8'h5F
`define BBSD_ACCESS_SPLIT 8'h60
`define BBSD_ACCESS_HIGH_BANK 4'hF
// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define BBSD_REG_CTRL 12'h000
`define BBSD_REG_INSTR 12'h004
`define BBSD_REG_PC 12'h008
`define BBSD_REG_BANK 12'h00C
`define BBSD_REG_FSR2 12'h010
`define BBSD_REG_FLAGS 12'h014
`define BBSD_REG_STATUS 12'h018
`define BBSD_REG_ADDR 12'h01C
`define BBSD_REG_FILEWIN 12'h020
`define BBSD_CTRL_XINST 0
`define BBSD_PC_RESET 21'h000000
`endif

// ### rtl/bbsd_pkg.sv
// Purpose: Types for the branch and bit-set decode block.
// Assumes: Nothing.
// Notes: Constants live in bbsd_params.svh.
package bbsd_pkg;
   typedef enum logic [2:0] {
      OP_NONE,
      OP_BRANCH_ALWAYS,
      OP_SET_BIT,
      OP_BRANCH_COND
   } bbsd_op_e;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_FLUSH
   } bbsd_state_e;
endpackage : bbsd_pkg

// ### rtl/bbsd_file_mem.sv
// Purpose: Data memory holding the general purpose file.
// Assumes: One write port, one combinational read port.
// Notes: Memory contents have no reset, and the module has no reset input or port registers.
`timescale 1ns/1ps
module bbsd_file_mem #(
   parameter int ADDR_W = 12,
   parameter int DEPTH = 4096
) (
   // Clock
   input wire logic sys_clk,
   input wire logic clkEn,
   // Read port
   input wire logic [ADDR_W-1:0] rdAddr,
   output logic [7:0] rdData,
   // Write port
   input wire logic wrEn,
   input wire logic [ADDR_W-1:0] wrAddr,
   input wire logic [7:0] wrData
);
   logic [7:0] mem [DEPTH];

   assign rdData = mem[rdAddr];

   always_ff @(posedge sys_clk) begin
      if (clkEn && wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end
endmodule : bbsd_file_mem

// ### rtl/bbsd_core.sv
// Purpose: Executes branch-always, conditional branches and bit-set.
// Assumes: Software writes an instruction word, which starts execution.
// Notes: One instruction is in flight at a time; an INSTR write during it waits.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "bbsd_params.svh"
module bbsd_core #(
   parameter int FILE_ADDR_W = 12,
   parameter int PC_W = 21
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [PC_W-1:0] branchTarget(input logic [PC_W-1:0] pc, input logic [10:0] off);
      logic [PC_W-1:0] ext;
      ext = PC_W'($signed(off));
      branchTarget = pc + PC_W'(2) + (ext << 1);
   endfunction : branchTarget

   function automatic logic [FILE_ADDR_W-1:0] fileAddr(input logic accessBit, input logic [7:0] f,
         input logic [3:0] bank, input logic xinst, input logic [FILE_ADDR_W-1:0] fsr2);
      if (accessBit) begin
         fileAddr = FILE_ADDR_W'({bank, f});
      end else if (xinst && f <= `BBSD_IDX_LIMIT) begin
         fileAddr = fsr2 + FILE_ADDR_W'(f);
      end else if (f < `BBSD_ACCESS_SPLIT) begin
         fileAddr = FILE_ADDR_W'({4'h0, f});
      end else begin
         fileAddr = FILE_ADDR_W'({`BBSD_ACCESS_HIGH_BANK, f});
      end
   endfunction : fileAddr

   // ----------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------
   logic dataPhase_r;
   logic dataWrite_r;
   logic [11:0] dataAddr_r;
   logic [31:0] rdata_nxt;
   logic [31:0] hrdata_r;
   logic hreadyout_r;

   wire logic addrValid = hsel && hready && htrans[1];

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         dataPhase_r <= 1'b0;
         dataWrite_r <= 1'b0;
         dataAddr_r <= 12'h000;
      end else if (clkEn) begin
         if (hreadyout_r) begin
            dataPhase_r <= addrValid;
            dataWrite_r <= hwrite;
            dataAddr_r <= haddr[11:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic xinst_r;
   logic [15:0] instr_r;
   logic instrPending_r;
   logic [PC_W-1:0] pc_r;
   logic [3:0] bank_r;
   logic [FILE_ADDR_W-1:0] fsr2_r;
   logic [3:0] flags_r;
   logic [FILE_ADDR_W-1:0] winAddr_r;
   bbsd_pkg::bbsd_state_e state_r;
   bbsd_pkg::bbsd_op_e op_r;
   logic [1:0] lastCycles_r;
   logic [1:0] cycleCnt_r;
   logic lastTaken_r;
   logic [FILE_ADDR_W-1:0] lastAddr_r;

   wire logic busWr = dataPhase_r && dataWrite_r && hreadyout_r;
   wire logic busBusy = state_r != bbsd_pkg::ST_IDLE;
   // Instruction writes stall while one executes or is pending; one right behind the last INSTR write is not stalled and replaces it.
   wire logic instrWrStall = dataPhase_r && dataWrite_r && dataAddr_r == `BBSD_REG_INSTR
         && (busBusy || instrPending_r);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         xinst_r <= 1'b0;
         bank_r <= 4'h0;
         fsr2_r <= '0;
         winAddr_r <= '0;
      end else if (clkEn && busWr) begin
         unique case (dataAddr_r)
            `BBSD_REG_CTRL: xinst_r <= hwdata[`BBSD_CTRL_XINST];
            `BBSD_REG_BANK: bank_r <= hwdata[3:0];
            `BBSD_REG_FSR2: fsr2_r <= hwdata[FILE_ADDR_W-1:0];
            `BBSD_REG_FILEWIN: winAddr_r <= hwdata[FILE_ADDR_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         flags_r <= 4'h0;
      end else if (clkEn && busWr && dataAddr_r == `BBSD_REG_FLAGS) begin
         flags_r <= hwdata[3:0];
      end
   end

   // ----------------------------------------------------------------
   // Decode and execute
   // ----------------------------------------------------------------
   wire logic isBranchAlways = instr_r[15:11] == `BBSD_OP_BRANCH_TOP;
   wire logic isSetBit = instr_r[15:12] == `BBSD_OP_SETBIT_TOP;
   wire logic isBcond = instr_r[15:11] == `BBSD_OP_BCOND_TOP;
   logic condFail;
   always_comb begin
      // Flags: bit0 carry, bit1 zero, bit2 overflow, bit3 negative.
      unique case (instr_r[10:8])
         `BBSD_OP_BCOND_Z: condFail = flags_r[1];
         `BBSD_OP_BCOND_OV: condFail = flags_r[2];
         `BBSD_OP_BCOND_C: condFail = flags_r[0];
         `BBSD_OP_BCOND_N: condFail = flags_r[3];
         default: condFail = 1'b1;
      endcase
   end
   wire logic bcondKnown = isBcond && instr_r[8];

   logic [FILE_ADDR_W-1:0] memRdAddr;
   logic [7:0] memRdData;
   logic memWrEn;
   logic [FILE_ADDR_W-1:0] setBitAddr;
   assign setBitAddr = fileAddr(instr_r[8], instr_r[7:0], bank_r, xinst_r, fsr2_r);
   assign memRdAddr = (state_r == bbsd_pkg::ST_EXEC && isSetBit) ? setBitAddr : winAddr_r;
   assign memWrEn = state_r == bbsd_pkg::ST_EXEC && isSetBit;

   bbsd_file_mem #(
      .ADDR_W(FILE_ADDR_W),
      .DEPTH(1 << FILE_ADDR_W)
   ) fileMem (
      .sys_clk(sys_clk),
      .clkEn(clkEn),
      .rdAddr(memRdAddr),
      .rdData(memRdData),
      .wrEn(memWrEn),
      .wrAddr(setBitAddr),
      .wrData(memRdData | (8'h01 << instr_r[11:9]))
   );

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         instr_r <= 16'h0000;
         instrPending_r <= 1'b0;
      end else if (clkEn) begin
         if (busWr && dataAddr_r == `BBSD_REG_INSTR) begin
            instr_r <= hwdata[15:0];
            instrPending_r <= 1'b1;
         end else if (state_r == bbsd_pkg::ST_IDLE) begin
            instrPending_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= bbsd_pkg::ST_IDLE;
         op_r <= bbsd_pkg::OP_NONE;
         pc_r <= `BBSD_PC_RESET;
         cycleCnt_r <= 2'h0;
         lastCycles_r <= 2'h0;
         lastTaken_r <= 1'b0;
         lastAddr_r <= '0;
      end else if (clkEn) begin
         unique case (state_r)
            bbsd_pkg::ST_IDLE: begin
               if (instrPending_r) begin
                  state_r <= bbsd_pkg::ST_EXEC;
                  cycleCnt_r <= 2'h1;
               end
            end
            bbsd_pkg::ST_EXEC: begin
               if (isBranchAlways) begin
                  op_r <= bbsd_pkg::OP_BRANCH_ALWAYS;
                  pc_r <= branchTarget(pc_r, instr_r[10:0]);
                  lastTaken_r <= 1'b1;
                  state_r <= bbsd_pkg::ST_FLUSH;
               end else if (bcondKnown) begin
                  op_r <= bbsd_pkg::OP_BRANCH_COND;
                  lastTaken_r <= !condFail;
                  if (condFail) begin
                     pc_r <= pc_r + PC_W'(2);
                     lastCycles_r <= cycleCnt_r;
                     state_r <= bbsd_pkg::ST_IDLE;
                  end else begin
                     pc_r <= branchTarget(pc_r, {{3{instr_r[7]}}, instr_r[7:0]});
                     state_r <= bbsd_pkg::ST_FLUSH;
                  end
               end else begin
                  op_r <= isSetBit ? bbsd_pkg::OP_SET_BIT : bbsd_pkg::OP_NONE;
                  lastTaken_r <= 1'b0;
                  if (isSetBit) begin
                     lastAddr_r <= setBitAddr;
                  end
                  pc_r <= pc_r + PC_W'(2);
                  lastCycles_r <= cycleCnt_r;
                  state_r <= bbsd_pkg::ST_IDLE;
               end
            end
            bbsd_pkg::ST_FLUSH: begin
               // Pipeline refill cycle: nothing is executed.
               lastCycles_r <= cycleCnt_r + 2'h1;
               state_r <= bbsd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read mux and bus response
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (dataAddr_r)
         `BBSD_REG_CTRL: rdata_nxt[0] = xinst_r;
         `BBSD_REG_INSTR: rdata_nxt[15:0] = instr_r;
         `BBSD_REG_PC: rdata_nxt[PC_W-1:0] = pc_r;
         `BBSD_REG_BANK: rdata_nxt[3:0] = bank_r;
         `BBSD_REG_FSR2: rdata_nxt[FILE_ADDR_W-1:0] = fsr2_r;
         `BBSD_REG_FLAGS: rdata_nxt[3:0] = flags_r;
         `BBSD_REG_STATUS: rdata_nxt[7:0] = {lastCycles_r, lastTaken_r, op_r, busBusy || instrPending_r, 1'b0};
         `BBSD_REG_ADDR: rdata_nxt[FILE_ADDR_W-1:0] = lastAddr_r;
         `BBSD_REG_FILEWIN: rdata_nxt[7:0] = memRdData;
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Reads answer one cycle after the address phase; hreadyout is low
   // for that cycle so the read mux reaches hrdata through a flip-flop.
   logic rdReady_r;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         hrdata_r <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
         rdReady_r <= 1'b0;
      end else if (clkEn) begin
         if (dataPhase_r && !dataWrite_r && !rdReady_r) begin
            hrdata_r <= rdata_nxt;
            hreadyout_r <= 1'b1;
            rdReady_r <= 1'b1;
         end else if (addrValid && hreadyout_r && !hwrite) begin
            hreadyout_r <= 1'b0;
            rdReady_r <= 1'b0;
         end else if (addrValid && hreadyout_r && hwrite && haddr[11:0] == `BBSD_REG_INSTR
               && (busBusy || instrPending_r)) begin
            hreadyout_r <= 1'b0;
            rdReady_r <= 1'b1;
         end else if (instrWrStall && !hreadyout_r) begin
            hreadyout_r <= 1'b0;
         end else begin
            hreadyout_r <= 1'b1;
            rdReady_r <= 1'b1;
         end
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
endmodule : bbsd_core

// ### sim/bbsd_core_sva.sv
// Purpose: Bus timing checks for bbsd_core.
// Assumes: One slave, so hready is hreadyout.
// Notes: Only sees top ports.
`timescale 1ns/1ps
`include "bbsd_params.svh"
module bbsd_core_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp
);
   logic take;
   logic rdPh_r;
   logic wrPh_r;
   assign take = hsel && hready && htrans[1] && hreadyout && clkEn;
   // Data phase trackers; reads and INSTR writes may stall, other writes may not.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdPh_r <= 1'b0;
         wrPh_r <= 1'b0;
      end else if (clkEn && hreadyout) begin
         rdPh_r <= take && !hwrite;
         wrPh_r <= take && hwrite && haddr[11:0] == `BBSD_REG_INSTR;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst || !clkEn);
   property p_okay; hresp == 1'b0; endproperty
   property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   property p_wr_fast; take && hwrite && haddr[11:0] != `BBSD_REG_INSTR |=> hreadyout; endproperty
   property p_idle_rdy; !rdPh_r && !wrPh_r |-> hreadyout; endproperty
   property p_stall; wrPh_r && !hreadyout |-> ##[1:4] hreadyout; endproperty
   property p_hold; $changed(hrdata) |-> rdPh_r; endproperty
   property p_rd_once; rdPh_r && !hreadyout |-> $past(take); endproperty
   property p_rst; disable iff (1'b0) sys_rst |=> hreadyout && hrdata == 32'h0; endproperty
   a_okay: assert property (p_okay) else $error("hresp not OKAY");
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   a_wr_fast: assert property (p_wr_fast) else $error("plain write stalled");
   a_idle_rdy: assert property (p_idle_rdy) else $error("not ready when idle");
   a_stall: assert property (p_stall) else $error("instruction stall too long");
   a_hold: assert property (p_hold) else $error("read data moved outside a read");
   a_rd_once: assert property (p_rd_once) else $error("extra read wait");
   a_rst: assert property (p_rst) else $error("outputs wrong in reset");
   c_rd: cover property (take && !hwrite);
   c_stall: cover property (wrPh_r && !hreadyout);
   c_rst: cover property ($fell(sys_rst));
endmodule : bbsd_core_sva
bind bbsd_core bbsd_core_sva u_bbsd_core_sva (.sys_clk, .sys_rst, .clkEn, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp);

// ### sim/bbsd_core_tb_top.sv
// Purpose: Self-checking bench for bbsd_core.
// Assumes: Engine idle 4 cycles after an INSTR write.
// Notes: File memory has no reset, so only the set bit is checked.
`timescale 1ns/1ps
`include "bbsd_params.svh"
module bbsd_core_tb_top;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clkEn = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, x, a;
   logic [20:0] pc = 21'h0;
   logic [10:0] n;
   logic [7:0] n8, f;
   logic [3:0] fl, bk;
   logic [2:0] b;
   logic [11:0] s;
   logic [11:0] regs [7] = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C};
   logic [7:0] cc [4] = '{8'hE1, 8'hE5, 8'hE3, 8'hE7};
   logic [3:0] fb [4] = '{4'h2, 4'h4, 4'h1, 4'h8};
   int bad_count = 0;
   int checks = 0;
   always #2 sys_clk = ~sys_clk;
   bbsd_core u_bbsd_core (.sys_clk, .sys_rst, .clkEn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
   task automatic final_report();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // A hung slave ends the run here rather than stalling forever.
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         bad_count++;
         final_report();
      end
   endtask : wait_rdy
   task automatic bus(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h0, ad};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus
   task automatic rdchk(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, ad, 32'h0);
      chk(rd & m, exp);
   endtask : rdchk
   task automatic run(input logic [15:0] ins);
      bus(1'b1, `BBSD_REG_INSTR, {16'h0, ins});
      repeat (4) @(posedge sys_clk);
   endtask : run
   function automatic logic [20:0] f_tgt(input logic [20:0] p, input logic [10:0] d);
      return p + 21'h2 + {{9{d[10]}}, d, 1'b0};
   endfunction : f_tgt
   function automatic logic [11:0] f_adr(input logic ac, input logic [7:0] ff, input logic xi);
      if (ac) return {bk, ff};
      if (xi && ff <= 8'h5F) return s + {4'h0, ff};
      return (ff < 8'h60) ? {4'h0, ff} : {4'hF, ff};
   endfunction : f_adr
   initial begin
      void'($urandom(74));
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      foreach (regs[i]) rdchk(regs[i], 32'hFFFFFFFF, 32'h0);
      bus(1'b1, 12'h024, 32'hFFFFFFFF);
      rdchk(12'h024, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, `BBSD_REG_PC, 32'h1234);
      rdchk(`BBSD_REG_PC, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 12; i++) begin
         n = (i == 0) ? 11'h3FF : (i == 1) ? 11'h400 : (i == 2) ? 11'h0 : 11'($urandom);
         run({`BBSD_OP_BRANCH_TOP, n});
         pc = f_tgt(pc, n);
         rdchk(`BBSD_REG_PC, 32'hFFFFFFFF, {11'h0, pc});
         rdchk(`BBSD_REG_STATUS, 32'hFE, 32'hA4);
      end
      run({5'h1B, 11'($urandom)});
      pc = pc + 21'h2;
      rdchk(`BBSD_REG_PC, 32'hFFFFFFFF, {11'h0, pc});
      for (int i = 0; i < 8; i++) begin
         fl = 4'($urandom);
         fl = i[0] ? (fl | fb[i / 2]) : (fl & ~fb[i / 2]);
         n8 = 8'($urandom);
         bus(1'b1, `BBSD_REG_FLAGS, {28'h0, fl});
         run({cc[i / 2], n8});
         pc = i[0] ? pc + 21'h2 : f_tgt(pc, {{3{n8[7]}}, n8});
         rdchk(`BBSD_REG_PC, 32'hFFFFFFFF, {11'h0, pc});
         rdchk(`BBSD_REG_STATUS, 32'hFE, i[0] ? 32'h4C : 32'hAC);
      end
      // Frozen clock enable must hold the branch until it is raised.
      bus(1'b1, `BBSD_REG_INSTR, {16'h0, `BBSD_OP_BRANCH_TOP, 11'h010});
      clkEn <= 1'b0;
      repeat (5) @(posedge sys_clk);
      clkEn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      pc = f_tgt(pc, 11'h010);
      rdchk(`BBSD_REG_PC, 32'hFFFFFFFF, {11'h0, pc});
      bus(1'b1, `BBSD_REG_INSTR, {16'h0, `BBSD_OP_BRANCH_TOP, 11'h001});
      run({`BBSD_OP_BRANCH_TOP, 11'h7FE});
      pc = f_tgt(f_tgt(pc, 11'h001), 11'h7FE);
      rdchk(`BBSD_REG_PC, 32'hFFFFFFFF, {11'h0, pc});
      for (int i = 0; i < 12; i++) begin
         x = (i < 2) ? 1'b1 : (i < 4) ? 1'b0 : 1'($urandom);
         a = (i < 4) ? 1'b0 : 1'($urandom);
         f = (i == 0) ? 8'h5F : (i == 1) ? 8'h60 : (i == 2) ? 8'h20 : (i == 3) ? 8'hA0 : 8'($urandom);
         {bk, b, s, fl} = 23'($urandom);
         bus(1'b1, `BBSD_REG_CTRL, {31'h0, x});
         bus(1'b1, `BBSD_REG_BANK, {28'h0, bk});
         bus(1'b1, `BBSD_REG_FSR2, {20'h0, s});
         bus(1'b1, `BBSD_REG_FLAGS, {28'h0, fl});
         run({`BBSD_OP_SETBIT_TOP, b, a, f});
         rdchk(`BBSD_REG_ADDR, 32'hFFF, {20'h0, f_adr(a, f, x)});
         rdchk(`BBSD_REG_FLAGS, 32'hF, {28'h0, fl});
         rdchk(`BBSD_REG_STATUS, 32'hFE, 32'h48);
         bus(1'b1, `BBSD_REG_FILEWIN, {20'h0, f_adr(a, f, x)});
         bus(1'b0, `BBSD_REG_FILEWIN, 32'h0);
         chk({31'h0, rd[b]}, 32'h1);
      end
      final_report();
   end
endmodule : bbsd_core_tb_top
